// ==== dv/pvil_cpu_model.sv ====
/*
  CPU core model: takes a shown request after a set delay.
  Assumes registered request outputs; delay F holds acceptance off.
*/
`timescale 1ns/1ps
module pvil_cpu_model
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic irqRequest,
  input wire logic [15:0] irqVector,
  input wire logic [3:0] delay,
  output logic cpuAccept,
  output logic [15:0] takenVec,
  output logic [7:0] takenCnt
);
  logic [3:0] waitCnt;

  // One-cycle accept pulse, only while a request is shown
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cpuAccept <= 1'b0;
      waitCnt <= 4'h0;
      takenCnt <= 8'h00;
    end
    else if (cpuAccept || !irqRequest || delay == 4'hF)
    begin
      cpuAccept <= 1'b0;
      waitCnt <= 4'h0;
    end
    else if (waitCnt >= delay)
    begin
      cpuAccept <= 1'b1;
      takenVec <= irqVector;
      takenCnt <= takenCnt + 8'h01;
    end
    else
      waitCnt <= waitCnt + 4'h1;
  end
endmodule

// ==== dv/pvil_ctrl_chk.sv ====
/*
  Port checker of pvil_ctrl.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module pvil_ctrl_chk
  import pvil_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrRdData,
  input wire logic softwareTrap,
  input wire logic cpuAccept,
  input wire logic cpuReturn,
  input wire logic stackedMasterEnable,
  input wire logic irqRequest,
  input wire logic [15:0] irqVector,
  input wire logic irqNonMaskable,
  input wire logic savedMasterEnable,
  input wire logic masterIrqEnable,
  input wire logic trapActionSelect,
  input wire logic wdogActionSelect,
  input wire logic trapResetReq,
  input wire logic wdogResetReq,
  input wire logic addressTrapIrq,
  input wire logic watchdogIrq
);
  // All checks on the system clock, off during reset except rst_idle_a
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // Accept counts only while a request is shown
  logic taken;
  assign taken = cpuAccept && irqRequest;

  rst_idle_a: assert property (disable iff (1'b0) sys_rst |=> !irqRequest)
    else $error("request during reset");
  idle_vector_a: assert property (!irqRequest |-> irqVector == VEC_RESET)
    else $error("idle vector wrong");
  mask_gate_a: assert property (irqRequest && !masterIrqEnable |-> irqNonMaskable)
    else $error("maskable request with master off");
  trap_irq_a: assert property (addressTrapIrq && !trapActionSelect |=> irqNonMaskable)
    else $error("trap request missing");
  trap_rst_a: assert property (addressTrapIrq && trapActionSelect |=> trapResetReq)
    else $error("trap reset missing");
  wdog_rst_a: assert property (watchdogIrq && wdogActionSelect |=> wdogResetReq)
    else $error("watchdog reset missing");
  accept_save_a: assert property (taken |=> !masterIrqEnable
    && savedMasterEnable == $past(masterIrqEnable)) else $error("master not stacked");
  return_load_a: assert property (cpuReturn && !taken |=>
    masterIrqEnable == $past(stackedMasterEnable)) else $error("master not restored");
  soft_vec_a: assert property (softwareTrap && !cpuAccept |=> irqVector == VEC_SOFT_TRAP)
    else $error("software vector wrong");
  read_idle_a: assert property (!$past(sfrRdEn) |-> sfrRdData == 8'h00)
    else $error("read data not idle");

  // Main scenarios reached
  cov_mask_c: cover property (taken && !irqNonMaskable);
  cov_nmi_c: cover property (taken && irqNonMaskable);
  cov_ret_c: cover property (cpuReturn);
endmodule

bind pvil_ctrl pvil_ctrl_chk chk (.clk_sys, .sys_rst, .sfrRdEn, .sfrRdData, .softwareTrap,
  .cpuAccept, .cpuReturn, .stackedMasterEnable, .irqRequest, .irqVector, .irqNonMaskable,
  .savedMasterEnable, .masterIrqEnable, .trapActionSelect, .wdogActionSelect, .trapResetReq,
  .wdogResetReq, .addressTrapIrq, .watchdogIrq);

// ==== dv/pvil_ctrl_tb.sv ====
/*
  Self-checking bench of pvil_ctrl with a CPU model.
  Assumes a 50 MHz clk_sys and synchronous reset.
*/
`timescale 1ns/1ps
module pvil_ctrl_tb;
  import pvil_pkg::*;
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
  logic clk_sys = 1'b0, sys_rst = 1'b1, sfrWrEn = 1'b0, sfrRdEn = 1'b0, cpuReturn = 1'b0;
  logic softwareTrap = 1'b0, badOpcodeTrap = 1'b0, stackedMasterEnable = 1'b0;
  logic trapActionSelect = 1'b1, wdogActionSelect = 1'b1, pinIrq0FunctionEnable = 1'b1;
  logic cpuAccept, irqRequest, irqNonMaskable, savedMasterEnable, masterIrqEnable;
  logic trapResetReq, wdogResetReq;
  logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData, rdv, pa, takenCnt;
  logic [15:0] irqVector, takenVec, en;
  logic [16:0] src = 17'h00000;
  logic [3:0] delay = 4'h0, n;
  int error_cnt = 0;
  int checks_done = 0;
  // Maskable rows: latch number above its vector
  logic [19:0] rows [12] = '{20'h4FFF6, 20'h5FFF4, 20'h6FFF2, 20'h7FFF0, 20'h8FFEE,
    20'h9FFEC, 20'hAFFEA, 20'hBFFE8, 20'hCFFE6, 20'hDFFE4, 20'hEFFE2, 20'hFFFE0};

  pvil_ctrl DUT (.clk_sys, .sys_rst, .sfrAddr, .sfrWrEn, .sfrRdEn, .sfrWrData, .sfrRdData,
    .softwareTrap, .badOpcodeTrap, .cpuAccept, .cpuReturn, .stackedMasterEnable, .irqRequest,
    .irqVector, .irqNonMaskable, .savedMasterEnable, .masterIrqEnable, .trapActionSelect,
    .wdogActionSelect, .pinIrq0FunctionEnable, .trapResetReq, .wdogResetReq,
    .addressTrapIrq(src[0]), .watchdogIrq(src[1]), .pinIrqZero(src[2]), .pinIrqOne(src[3]),
    .timeBaseIrq(src[4]), .timerOneIrq(src[5]), .pinIrqTwo(src[6]), .timerFourIrq(src[7]),
    .timerThreeIrq(src[8]), .pinIrqThree(src[9]), .serialPortIrq(src[10]),
    .uartReceiveIrq(src[11]), .pinIrqFour(src[12]), .pinIrqFive(src[13]),
    .timerTwoIrq(src[14]), .uartTransmitIrq(src[15]), .converterDoneIrq(src[16]));
  pvil_cpu_model cpu (.clk_sys, .sys_rst, .irqRequest, .irqVector, .delay, .cpuAccept,
    .takenVec, .takenCnt);

  // System clock
  always #10 clk_sys = ~clk_sys;

  // One cycle: optional byte write beside source pulses
  task automatic cyc(input logic we, input logic [7:0] a, d, input logic [16:0] m);
    @(posedge clk_sys);
    sfrWrEn <= we;
    sfrAddr <= a;
    sfrWrData <= d;
    src <= m;
    @(posedge clk_sys);
    sfrWrEn <= 1'b0;
    src <= 17'h00000;
    #1;
  endtask

  // Byte read; data follows the read edge
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    sfrRdEn <= 1'b1;
    sfrAddr <= a;
    @(posedge clk_sys);
    sfrRdEn <= 1'b0;
    #1;
    rdv = sfrRdData;
  endtask

  // Waits for the CPU model to take a request
  task automatic take(input logic [15:0] v);
    logic [7:0] c;
    c = takenCnt;
    repeat (40) if (takenCnt == c) @(posedge clk_sys) #1;
    `CHK("taken count", c + 8'h01, takenCnt)
    `CHK("vector", v, takenVec)
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Cuts a hung run short
  initial
  begin
    #100000;
    error_cnt++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int a = 8'h3A; a < 8'h40; a++)
    begin
      rd(8'(a));
      `CHK("reset byte", 8'h00, rdv)
    end
    foreach (rows[i])
    begin
      n = rows[i][19:16];
      en = 16'h0001 << n;
      pa = n > 4'h7 ? ADDR_PENDING_HIGH : ADDR_PENDING_LOW;
      delay = 4'(i % 3);
      cyc(1'b1, ADDR_ENABLE_HIGH, en[15:8], 17'h00000);
      cyc(1'b1, ADDR_ENABLE_LOW, en[7:0], 17'h00001 << (n - 4'h2));
      `CHK("masked", 1'b0, irqRequest)
      rd(pa);
      `CHK("latch set", n > 4'h7 ? en[15:8] : en[7:0], rdv)
      cyc(1'b1, ADDR_ENABLE_LOW, en[7:0] | 8'h01, 17'h00000);
      take(rows[i][15:0]);
      @(posedge clk_sys) #1;
      `CHK("master", 1'b0, masterIrqEnable)
      `CHK("saved", 1'b1, savedMasterEnable)
      rd(pa);
      `CHK("cleared", 8'h00, rdv)
    end
    cyc(1'b1, ADDR_SHARED_SELECT, 8'h07, 17'h00000);
    rd(ADDR_SHARED_SELECT);
    `CHK("select", 8'h07, rdv)
    cyc(1'b0, 8'h00, 8'h00, 17'h03800);
    rd(ADDR_PENDING_HIGH);
    `CHK("dropped", 8'h00, rdv)
    cyc(1'b0, 8'h00, 8'h00, 17'h1C000);
    rd(ADDR_PENDING_HIGH);
    `CHK("shared", 8'hE0, rdv)
    cyc(1'b1, ADDR_PENDING_HIGH, 8'h5F, 17'h00000);
    rd(ADDR_PENDING_HIGH);
    `CHK("write clear", 8'h40, rdv)
    cyc(1'b1, ADDR_PENDING_HIGH, 8'h00, 17'h08000);
    rd(ADDR_PENDING_HIGH);
    `CHK("set wins", 8'h40, rdv)
    cyc(1'b1, ADDR_PENDING_LOW, 8'hFF, 17'h00000);
    rd(ADDR_PENDING_LOW);
    `CHK("no set", 8'h00, rdv)
    cyc(1'b1, ADDR_PENDING_HIGH, 8'h00, 17'h00001);
    `CHK("trap reset", 1'b1, trapResetReq)
    `CHK("no trap irq", 1'b0, irqRequest)
    @(posedge clk_sys);
    trapActionSelect <= 1'b0;
    wdogActionSelect <= 1'b0;
    delay <= 4'hF;
    cyc(1'b0, 8'h00, 8'h00, 17'h00002);
    `CHK("wdog vector", 16'hFFF8, irqVector)
    `CHK("nmi", 1'b1, irqNonMaskable)
    cyc(1'b0, 8'h00, 8'h00, 17'h00001);
    `CHK("trap first", 16'hFFFA, irqVector)
    @(posedge clk_sys);
    softwareTrap <= 1'b1;
    @(posedge clk_sys);
    delay <= 4'h0;
    take(VEC_SOFT_TRAP);
    @(posedge clk_sys);
    softwareTrap <= 1'b0;
    take(16'hFFFA);
    take(16'hFFF8);
    @(posedge clk_sys);
    badOpcodeTrap <= 1'b1;
    take(VEC_SOFT_TRAP);
    @(posedge clk_sys);
    badOpcodeTrap <= 1'b0;
    wdogActionSelect <= 1'b1;
    cyc(1'b0, 8'h00, 8'h00, 17'h00002);
    `CHK("wdog reset", 1'b1, wdogResetReq)
    @(posedge clk_sys);
    pinIrq0FunctionEnable <= 1'b0;
    cyc(1'b1, ADDR_ENABLE_LOW, 8'h10, 17'h00004);
    cyc(1'b1, ADDR_ENABLE_LOW, 8'h11, 17'h00000);
    `CHK("pin zero gate", 1'b0, irqRequest)
    @(posedge clk_sys);
    pinIrq0FunctionEnable <= 1'b1;
    take(16'hFFF6);
    @(posedge clk_sys);
    stackedMasterEnable <= 1'b1;
    cpuReturn <= 1'b1;
    @(posedge clk_sys);
    cpuReturn <= 1'b0;
    #1;
    `CHK("restored", 1'b1, masterIrqEnable)
    // Reset in mid-run with a latch set
    cyc(1'b0, 8'h00, 8'h00, 17'h00008);
    rd(ADDR_PENDING_LOW);
    `CHK("pre reset", 8'h20, rdv)
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(ADDR_PENDING_LOW);
    `CHK("reset clears", 8'h00, rdv)
    `CHK("reset master", 1'b0, masterIrqEnable)
    `CHK("reset vector", VEC_RESET, irqVector)
    finish_test();
  end
endmodule

// ==== shared/pvil_pkg.sv ====
/*
  Shared constants of the prioritized vectored interrupt latches:
  special-function addresses, field positions, reset values and vectors.
  Assumes an 8-bit special-function bus and a 16-bit vector space.
*/
package pvil_pkg;
  // Special-function byte addresses
  localparam logic [7:0] ADDR_ENABLE_LOW = 8'h3A;
  localparam logic [7:0] ADDR_ENABLE_HIGH = 8'h3B;
  localparam logic [7:0] ADDR_PENDING_LOW = 8'h3C;
  localparam logic [7:0] ADDR_PENDING_HIGH = 8'h3D;
  localparam logic [7:0] ADDR_SHARED_SELECT = 8'h3E;

  // Field positions
  localparam int MASTER_ENABLE_BIT = 0;
  localparam int TRAP_LATCH = 2;
  localparam int WDOG_LATCH = 3;
  localparam int FIRST_MASKABLE = 4;
  localparam int LATCH_COUNT = 16;
  localparam int SHARED_LEVELS = 3;
  localparam int SOURCE_COUNT = 19;

  // Latch bits that exist; bits 1..0 read as zero
  localparam logic [15:0] LATCH_MASK = 16'hFFFC;
  // Enable bits that exist: per-source enables 15..4 and the master enable
  localparam logic [15:0] ENABLE_MASK = 16'hFFF1;
  localparam logic [2:0] SELECT_MASK = 3'h7;

  // Values after reset
  localparam logic [15:0] PENDING_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [2:0] SELECT_RESET = 3'h0;

  // Vectors
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_SOFT_TRAP = 16'hFFFC;
endpackage

// ==== src/pvil_ctrl.sv ====
/*
  Interrupt controller top: request latches, enables, shared-level
  selection, fixed-priority vectoring toward the CPU core and the
  special-function byte registers at 3Ah..3Eh.
  Assumes all source requests, strobes and control bits come from logic on
  clk_sys; pin requests are edge-detected and synchronised upstream.
*/
// Behaviour
// - Nineteen sources, three levels shared pairwise
// - Trap, watchdog, software, opcode traps ignore enables
// - Source request sets its pending latch
// - Maskable needs master and per-source enable
// - Simultaneous requests taken in fixed order
// - Fixed vectors FFFE, FFFC, FFFA, FFF8
// - Latch n vectors FFFE-2n; pin zero function gate
// - Level select bit picks first or second
// - Software and opcode traps have no latch
// - Acceptance clears the accepted latch
// - Reset forces every latch to zero
// - Latches readable as two consecutive bytes
// - Writing zero clears, one leaves latch
// - Writes can never set a latch
// - Trap interrupt only when trap action zero
// - Watchdog interrupt only when watchdog action zero
// - Accept saves then clears master; return restores
// - Master bit 0, source enables 15..4, reset zero
// - Unselected shared source requests are discarded
`timescale 1ns/1ps
module pvil_ctrl
  import pvil_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Special-function byte bus
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  // CPU core side
  input wire logic softwareTrap,
  input wire logic badOpcodeTrap,
  input wire logic cpuAccept,
  input wire logic cpuReturn,
  input wire logic stackedMasterEnable,
  output logic irqRequest,
  output logic [15:0] irqVector,
  output logic irqNonMaskable,
  output logic savedMasterEnable,
  output logic masterIrqEnable,
  // Control bits from the watchdog and port blocks
  input wire logic trapActionSelect,
  input wire logic wdogActionSelect,
  input wire logic pinIrq0FunctionEnable,
  output logic trapResetReq,
  output logic wdogResetReq,
  // Source request pulses
  input wire logic addressTrapIrq,
  input wire logic watchdogIrq,
  input wire logic pinIrqZero,
  input wire logic pinIrqOne,
  input wire logic timeBaseIrq,
  input wire logic timerOneIrq,
  input wire logic pinIrqTwo,
  input wire logic timerFourIrq,
  input wire logic timerThreeIrq,
  input wire logic pinIrqThree,
  input wire logic serialPortIrq,
  input wire logic uartReceiveIrq,
  input wire logic timerTwoIrq,
  input wire logic pinIrqFour,
  input wire logic uartTransmitIrq,
  input wire logic pinIrqFive,
  input wire logic converterDoneIrq
);
  // Stored state and its next values
  logic [15:0] pendingLatch;
  logic [15:0] enableReg;
  logic [2:0] sharedSourceSelect;
  logic [3:0] grantIndex;
  logic grantIsLatch;
  logic [15:0] next_pendingLatch;
  logic [15:0] next_enableReg;
  logic [2:0] next_sharedSourceSelect;
  logic [3:0] next_grantIndex;
  logic next_grantIsLatch;
  logic next_irqRequest;
  logic [15:0] next_irqVector;
  logic next_irqNonMaskable;
  logic next_savedMasterEnable;
  logic [7:0] next_sfrRdData;
  logic next_trapResetReq;
  logic next_wdogResetReq;

  // Working signals
  logic [2:0] sharedReq;
  logic [15:0] setReq;
  logic [15:0] clearMask;
  logic [15:0] acceptMask;
  logic [15:0] eligible;
  logic [15:0] maskableGate;
  logic encFound;
  logic [3:0] encIndex;
  logic acceptNow;
  logic softPending;

  // Shared levels: latch 13, 14, 15 each fed by one of two sources
  pvil_source_mux #(
    .LEVELS(SHARED_LEVELS)
  ) u_mux (
    .firstReq({pinIrqFive, pinIrqFour, uartReceiveIrq}),
    .secondReq({converterDoneIrq, uartTransmitIrq, timerTwoIrq}),
    .selectSecond({sharedSourceSelect[0], sharedSourceSelect[1], sharedSourceSelect[2]}),
    .chosenReq(sharedReq)
  );

  // Set requests per latch; bits 1..0 have no latch
  always_comb
  begin
    setReq = 16'h0000;
    setReq[TRAP_LATCH] = addressTrapIrq & ~trapActionSelect;
    setReq[WDOG_LATCH] = watchdogIrq & ~wdogActionSelect;
    setReq[4] = pinIrqZero;
    setReq[5] = pinIrqOne;
    setReq[6] = timeBaseIrq;
    setReq[7] = timerOneIrq;
    setReq[8] = pinIrqTwo;
    setReq[9] = timerFourIrq;
    setReq[10] = timerThreeIrq;
    setReq[11] = pinIrqThree;
    setReq[12] = serialPortIrq;
    setReq[15:13] = sharedReq;
  end

  // Enable condition per latch: trap and watchdog always, rest gated by the
  // master value left after this cycle's write or accept
  always_comb
  begin
    maskableGate = 16'h0000;
    maskableGate[TRAP_LATCH] = 1'b1;
    maskableGate[WDOG_LATCH] = 1'b1;
    for (int i = FIRST_MASKABLE; i < LATCH_COUNT; i++)
    begin
      maskableGate[i] = next_enableReg[MASTER_ENABLE_BIT] & enableReg[i];
    end
    maskableGate[FIRST_MASKABLE] = maskableGate[FIRST_MASKABLE] & pinIrq0FunctionEnable;
  end

  // Acceptance of the request presented in the previous cycle
  assign acceptNow = cpuAccept & irqRequest;
  assign softPending = softwareTrap | badOpcodeTrap;

  // Lowest latch index wins among eligible requests
  pvil_priority_enc #(
    .WIDTH(LATCH_COUNT)
  ) u_enc (
    .req(eligible),
    .found(encFound),
    .index(encIndex)
  );

  // Next values of latches, enables, select, read data and CPU outputs
  always_comb
  begin
    next_enableReg = enableReg;
    next_sharedSourceSelect = sharedSourceSelect;
    next_savedMasterEnable = savedMasterEnable;
    next_sfrRdData = 8'h00;
    clearMask = 16'h0000;
    acceptMask = 16'h0000;
    // Writes of zero clear latch bits; ones are ignored
    if (sfrWrEn && sfrAddr == ADDR_PENDING_LOW)
    begin
      clearMask[7:0] = ~sfrWrData;
    end
    if (sfrWrEn && sfrAddr == ADDR_PENDING_HIGH)
    begin
      clearMask[15:8] = ~sfrWrData;
    end
    if (acceptNow && grantIsLatch)
    begin
      acceptMask[grantIndex] = 1'b1;
    end
    // New requests win over clears; writes never set a latch
    next_pendingLatch = ((pendingLatch & ~clearMask & ~acceptMask) | setReq) & LATCH_MASK;
    // Enable and select registers
    if (sfrWrEn && sfrAddr == ADDR_ENABLE_LOW)
    begin
      next_enableReg[7:0] = sfrWrData & ENABLE_MASK[7:0];
    end
    if (sfrWrEn && sfrAddr == ADDR_ENABLE_HIGH)
    begin
      next_enableReg[15:8] = sfrWrData & ENABLE_MASK[15:8];
    end
    if (sfrWrEn && sfrAddr == ADDR_SHARED_SELECT)
    begin
      next_sharedSourceSelect = sfrWrData[2:0] & SELECT_MASK;
    end
    // Master enable: accept beats return, return beats a write
    if (acceptNow)
    begin
      next_savedMasterEnable = enableReg[MASTER_ENABLE_BIT];
      next_enableReg[MASTER_ENABLE_BIT] = 1'b0;
    end
    else if (cpuReturn)
    begin
      next_enableReg[MASTER_ENABLE_BIT] = stackedMasterEnable;
    end
    // Registered read data; unmapped addresses read zero
    if (sfrRdEn)
    begin
      case (sfrAddr)
        ADDR_ENABLE_LOW: next_sfrRdData = enableReg[7:0];
        ADDR_ENABLE_HIGH: next_sfrRdData = enableReg[15:8];
        ADDR_PENDING_LOW: next_sfrRdData = pendingLatch[7:0];
        ADDR_PENDING_HIGH: next_sfrRdData = pendingLatch[15:8];
        ADDR_SHARED_SELECT: next_sfrRdData = {5'h00, sharedSourceSelect};
        default: next_sfrRdData = 8'h00;
      endcase
    end
    // Reset requests when an event is steered to reset
    next_trapResetReq = addressTrapIrq & trapActionSelect;
    next_wdogResetReq = watchdogIrq & wdogActionSelect;
  end

  // Eligible requests from the next latch state, so a cleared latch drops at once
  always_comb
  begin
    eligible = next_pendingLatch & maskableGate & LATCH_MASK;
  end

  // Request line and vector; software traps first, then latches by index
  always_comb
  begin
    next_irqRequest = 1'b0;
    next_irqVector = VEC_RESET;
    next_irqNonMaskable = 1'b0;
    next_grantIndex = 4'h0;
    next_grantIsLatch = 1'b0;
    if (softPending && !acceptNow)
    begin
      next_irqRequest = 1'b1;
      next_irqVector = VEC_SOFT_TRAP;
      next_irqNonMaskable = 1'b1;
    end
    else if (encFound)
    begin
      next_irqRequest = 1'b1;
      next_irqVector = VEC_RESET - {11'h000, encIndex, 1'b0};
      next_irqNonMaskable = (encIndex < 4'(FIRST_MASKABLE));
      next_grantIndex = encIndex;
      next_grantIsLatch = 1'b1;
    end
  end

  // Register everything; synchronous reset clears all state except irqVector, which loads VEC_RESET
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pendingLatch <= PENDING_RESET;
      enableReg <= ENABLE_RESET;
      sharedSourceSelect <= SELECT_RESET;
      grantIndex <= 4'h0;
      grantIsLatch <= 1'b0;
      irqRequest <= 1'b0;
      irqVector <= VEC_RESET;
      irqNonMaskable <= 1'b0;
      savedMasterEnable <= 1'b0;
      sfrRdData <= 8'h00;
      trapResetReq <= 1'b0;
      wdogResetReq <= 1'b0;
    end
    else
    begin
      pendingLatch <= next_pendingLatch;
      enableReg <= next_enableReg;
      sharedSourceSelect <= next_sharedSourceSelect;
      grantIndex <= next_grantIndex;
      grantIsLatch <= next_grantIsLatch;
      irqRequest <= next_irqRequest;
      irqVector <= next_irqVector;
      irqNonMaskable <= next_irqNonMaskable;
      savedMasterEnable <= next_savedMasterEnable;
      sfrRdData <= next_sfrRdData;
      trapResetReq <= next_trapResetReq;
      wdogResetReq <= next_wdogResetReq;
    end
  end

  // Master enable as a plain status output
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      masterIrqEnable <= 1'b0;
    end
    else
    begin
      masterIrqEnable <= next_enableReg[MASTER_ENABLE_BIT];
    end
  end
endmodule

// ==== src/pvil_priority_enc.sv ====
/*
  Fixed-priority encoder: finds the lowest-numbered active request.
  Assumes a lower index means a higher priority.
*/
`timescale 1ns/1ps
module pvil_priority_enc
  import pvil_pkg::*;
#(
  parameter int WIDTH = LATCH_COUNT
)
(
  input wire logic [WIDTH-1:0] req,
  output logic found,
  output logic [$clog2(WIDTH)-1:0] index
);
  // Scan from the top so that the lowest active index is kept last
  always_comb
  begin
    found = 1'b0;
    index = '0;
    for (int i = WIDTH - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        found = 1'b1;
        index = i[$clog2(WIDTH)-1:0];
      end
    end
  end
endmodule

// ==== src/pvil_source_mux.sv ====
/*
  Source selection for the shared priority levels: one request of each
  pair reaches the latch, the other is dropped.
  Assumes request inputs are one-cycle pulses on the system clock.
*/
`timescale 1ns/1ps
module pvil_source_mux
  import pvil_pkg::*;
#(
  parameter int LEVELS = SHARED_LEVELS
)
(
  input wire logic [LEVELS-1:0] firstReq,
  input wire logic [LEVELS-1:0] secondReq,
  input wire logic [LEVELS-1:0] selectSecond,
  output logic [LEVELS-1:0] chosenReq
);
  genvar gi;
  // Per level: select 0 passes the first source, 1 the second
  generate
    for (gi = 0; gi < LEVELS; gi++)
    begin : g_level
      assign chosenReq[gi] = selectSecond[gi] ? secondReq[gi] : firstReq[gi];
    end
  endgenerate
endmodule
